// >>> sim/nfb_host.sv
// Host pin driver and array stand-in facing the flash bus interface
`timescale 1ns/1ps
module nfb_host import nfb_pkg::*; (
	input wire logic i_clk,
	input wire logic [ADDR_MSB_BIG:ADDR_LSB] i_arr_addr,
	output nfb_pins_s o_pins,
	output logic [ADDR_MSB_BIG:ADDR_LSB] o_addr,
	output logic [DQ_W-1:0] o_dq,
	output logic o_link_clk,
	output logic [DQ_W-1:0] o_arr_rdata
);
	logic link_run;

	// ==========================================================
	// Link clock, running through reset, stopped low outside frames after it
	initial begin
		o_link_clk = 1'b0;
		link_run = 1'b1;
		#1.3;
		forever begin
			#3;
			o_link_clk = link_run ? ~o_link_clk : 1'b0;
		end
	end

	// ==========================================================
	// Pins held quiet while the system sits in reset
	initial begin
		o_pins = 7'h78;
		o_addr = '0;
		o_dq = 16'h0000;
	end

	// Array word derived from address bits 16 to 1, so reads differ only where those bits differ
	assign o_arr_rdata = i_arr_addr[16:1] ^ 16'h5a5a;

	// ==========================================================
	// Bus cycles
	task automatic drive(input logic ce, oe, we, adv, input logic [ADDR_MSB_BIG:ADDR_LSB] a);
		@(posedge i_clk);
		o_pins <= {ce, oe, we, adv, o_pins.rst_n, o_pins.wp_n, o_pins.prog_lockout};
		o_addr <= a;
	endtask : drive

	task automatic flags(input logic rst_n, wp_n, lock);
		@(posedge i_clk);
		o_pins <= {o_pins.ce_n, o_pins.oe_n, o_pins.we_n, o_pins.adv_n, rst_n, wp_n, lock};
	endtask : flags

	task automatic wr(input logic [ADDR_MSB_BIG:ADDR_LSB] a, input logic [DQ_W-1:0] d, input logic ce_first);
		@(posedge i_clk);
		o_dq <= d;
		drive(1'b0, 1'b1, 1'b0, 1'b0, a);
		repeat (4) @(posedge i_clk);
		o_pins <= {ce_first, 1'b1, ~ce_first, 1'b1, o_pins.rst_n, o_pins.wp_n, o_pins.prog_lockout};
		@(posedge i_clk);
		// Released data lines must not keep the old word
		o_pins <= {1'b1, 1'b1, 1'b1, 1'b1, o_pins.rst_n, o_pins.wp_n, o_pins.prog_lockout};
		o_dq <= ~d;
	endtask : wr
endmodule : nfb_host

// >>> sim/tb.sv
// Self-checking bench for the flash bus interface
`timescale 1ns/1ps
module tb import nfb_pkg::*;;
	logic i_clk, i_rst, i_arr_rvalid, i_op_busy, i_rcr_wr;
	logic [DQ_W-1:0] i_rcr_data, arr_rdata, i_dq, o_dq;
	logic link_clk, o_dq_oe_n, o_wait, o_wait_oe_n, o_abort, o_ldown_ovr, o_active, o_sync_mode;
	nfb_pins_s pins;
	nfb_wreq_s o_wreq;
	logic [ADDR_MSB_BIG:ADDR_LSB] i_addr, o_arr_addr, o_wr_addr;
	logic [SR_W-1:0] o_status;
	int error_cnt, checks_done, cycles;

	nfb_host host_u (.i_clk(i_clk), .i_arr_addr(o_arr_addr), .o_pins(pins), .o_addr(i_addr),
		.o_dq(i_dq), .o_link_clk(link_clk), .o_arr_rdata(arr_rdata));
	nfb_bus_if dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_link_clk(link_clk), .i_pins(pins),
		.i_addr(i_addr), .i_dq(i_dq), .i_arr_rdata(arr_rdata), .i_arr_rvalid(i_arr_rvalid),
		.i_op_busy(i_op_busy), .i_rcr_wr(i_rcr_wr), .i_rcr_data(i_rcr_data), .o_dq(o_dq),
		.o_dq_oe_n(o_dq_oe_n), .o_wait(o_wait), .o_wait_oe_n(o_wait_oe_n), .o_arr_addr(o_arr_addr),
		.o_wreq(o_wreq), .o_wr_addr(o_wr_addr), .o_abort(o_abort), .o_ldown_ovr(o_ldown_ovr),
		.o_active(o_active), .o_sync_mode(o_sync_mode), .o_status(o_status));

	// ==========================================================
	// Clock, timeout and helpers
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc

	task automatic end_of_test();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// ==========================================================
	// Scenarios
	task automatic t_async_read();
		host_u.drive(1'b0, 1'b0, 1'b1, 1'b0, 23'h012345);
		cyc(5);
		chk("addr", 23'h012345, o_arr_addr);
		chk("dq_oe", 0, o_dq_oe_n);
		chk("dq", 16'h2345 ^ 16'h5a5a, o_dq);
		chk("wait", 1, o_wait);
		host_u.drive(1'b0, 1'b0, 1'b1, 1'b1, 23'h000777);
		cyc(5);
		chk("held", 23'h012345, o_arr_addr);
		host_u.drive(1'b0, 1'b1, 1'b1, 1'b1, 23'h000777);
		cyc(5);
		chk("oe_off", 2'b11, {o_dq_oe_n, o_wait_oe_n});
		host_u.drive(1'b1, 1'b0, 1'b1, 1'b1, 23'h000777);
		cyc(5);
		chk("standby", 2'b11, {o_dq_oe_n, o_wait_oe_n});
	endtask : t_async_read

	task automatic t_write(input logic [ADDR_MSB_BIG:ADDR_LSB] a, input logic [DQ_W-1:0] d, input logic cf, lock);
		host_u.flags(1'b1, 1'b1, lock);
		host_u.wr(a, d, cf);
		repeat (8) begin
			cyc(1);
			if (o_wreq.stb === 1'b1)
				break;
		end
		chk("stb", 1, o_wreq.stb);
		chk("wdata", d, o_wreq.data);
		chk("waddr", a, o_wr_addr);
		chk("allow", !lock, o_wreq.allow);
		cyc(2);
		chk("lock_err", lock, o_status[SR_LOCKOUT_BIT]);
	endtask : t_write

	task automatic t_sync_wait();
		host_u.link_run = 1'b1;
		i_rcr_wr <= 1'b1;
		i_rcr_data <= 16'h0400;
		cyc(1);
		i_rcr_wr <= 1'b0;
		i_arr_rvalid <= 1'b0;
		cyc(1);
		chk("sync", 1, o_sync_mode);
		host_u.drive(1'b0, 1'b0, 1'b1, 1'b0, 23'h400abc);
		cyc(10);
		chk("saddr", 23'h400abc, o_arr_addr);
		chk("wait_on", 1, o_wait);
		i_arr_rvalid <= 1'b1;
		cyc(3);
		chk("wait_off", 0, o_wait);
		host_u.drive(1'b1, 1'b1, 1'b1, 1'b1, 23'h400abc);
		cyc(4);
		host_u.link_run = 1'b0;
	endtask : t_sync_wait

	task automatic t_hw_reset();
		i_op_busy <= 1'b1;
		cyc(5);
		chk("active", 1, o_active);
		host_u.flags(1'b0, 1'b0, 1'b0);
		repeat (6) begin
			cyc(1);
			if (o_abort === 1'b1)
				break;
		end
		chk("abort", 1, o_abort);
		cyc(3);
		chk("async", 0, o_sync_mode);
		chk("status", 8'h80, o_status);
		chk("ldown", 0, o_ldown_ovr);
		i_op_busy <= 1'b0;
		host_u.flags(1'b1, 1'b1, 1'b0);
		cyc(4);
		chk("ovr", 1, o_ldown_ovr);
	endtask : t_hw_reset

	// ==========================================================
	// Main sequence
	initial begin
		i_rst <= 1'b1;
		i_arr_rvalid <= 1'b1;
		i_op_busy <= 1'b0;
		i_rcr_wr <= 1'b0;
		i_rcr_data <= 16'h8000;
		error_cnt = 0;
		checks_done = 0;
		cycles = 0;
		cyc(3);
		i_rst <= 1'b0;
		cyc(2);
		chk("rst_status", 8'h80, o_status);
		chk("rst_dq_oe", 1, o_dq_oe_n);
		host_u.link_run = 1'b0;
		host_u.flags(1'b1, 1'b1, 1'b0);
		cyc(3);
		t_async_read();
		t_write(23'h7fffff, 16'ha5c3, 1'b0, 1'b0);
		t_write(23'h000001, 16'h0ff0, 1'b1, 1'b1);
		t_sync_wait();
		t_hw_reset();
		end_of_test();
	end
endmodule : tb

// >>> src/nfb_bus_if.sv
// Pin-level bus interface of a parallel NOR flash
// Function
// R1 - Word address spans bit 23 down to 1, or 22 down to 1.
// R2 - Data lines take writes, drive reads, float unless selected and enabled.
// R3 - Sync mode captures address on first of address_valid_n rise or clock edge.
// R4 - Async mode holds address at address_valid_n rise, flows through while low.
// R5 - Deselected chip floats data and wait regardless of output enable.
// R6 - Output enable high floats data and wait.
// R7 - Hardware reset stops automation, blocks writes, floats outputs, returns async.
// R8 - Wait polarity comes from read config bit 10.
// R9 - Wait asserted while sync read data invalid, else deasserted.
// R10 - Host reads with reset and write strobe high, select and enable low.
// R11 - Host writes with select and strobe low, reset and enable high.
// R12 - Write address and data taken at first rising strobe or select.
// R13 - Write protect low keeps lock-down; high overrides it.
// R14 - Program lockout level blocks any array change.
// R15 - After reset: async array read, status 0x80.
// R16 - Reset during program or erase aborts it; target becomes undefined.
// R17 - Program or erase runs on after deselect; device stays active.
// R18 - Host waits wake-up time after reset before reads and writes.
// R19 - Host supplies running clock for sync reads only.
// R20 - System ties hardware reset to processor reset.
// R21 - Host keeps select and write strobe high during power-on and reset.
// R22 - Sync burst only after read config programmed; else async page reads.
`timescale 1ns/1ps
module nfb_bus_if import nfb_pkg::*; #(
	parameter int ADDR_MSB = ADDR_MSB_BIG
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_link_clk,
	input wire nfb_pins_s i_pins,
	input wire logic [ADDR_MSB:ADDR_LSB] i_addr,
	input wire logic [DQ_W-1:0] i_dq,
	input wire logic [DQ_W-1:0] i_arr_rdata,
	input wire logic i_arr_rvalid,
	input wire logic i_op_busy,
	input wire logic i_rcr_wr,
	input wire logic [DQ_W-1:0] i_rcr_data,
	output logic [DQ_W-1:0] o_dq,
	output logic o_dq_oe_n,
	output logic o_wait,
	output logic o_wait_oe_n,
	output logic [ADDR_MSB:ADDR_LSB] o_arr_addr,
	output nfb_wreq_s o_wreq,
	output logic [ADDR_MSB:ADDR_LSB] o_wr_addr,
	output logic o_abort,
	output logic o_ldown_ovr,
	output logic o_active,
	output logic o_sync_mode,
	output logic [SR_W-1:0] o_status
);

	// ==========================================================
	// Pin synchronisers, core domain
	nfb_pins_s p;
	logic [ADDR_MSB:ADDR_LSB] a_s;
	logic [DQ_W-1:0] d_s;

	nfb_sync #(.W($bits(nfb_pins_s)), .RST_VAL(PINS_IDLE)) u_pin_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d(i_pins),
		.o_q(p)
	);

	nfb_sync #(.W(ADDR_MSB)) u_addr_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d(i_addr),
		.o_q(a_s)
	);

	nfb_sync #(.W(DQ_W)) u_dq_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d(i_dq),
		.o_q(d_s)
	);

	// ==========================================================
	// Bus operation decode
	logic hw_on;
	logic rd_sel;
	logic wr_sel;
	logic out_sel;
	logic [DQ_W-1:0] rcr_q;
	logic sync_mode;
	logic wt;
	logic sync_q;

	assign hw_on = p.rst_n;
	assign rd_sel = !p.ce_n && !p.oe_n && p.we_n && hw_on;
	assign wr_sel = !p.ce_n && !p.we_n && p.oe_n && hw_on;
	assign out_sel = !p.ce_n && !p.oe_n && hw_on;
	assign sync_mode = !rcr_q[RCR_ASYNC_BIT];
	assign wt = rcr_q[RCR_WT_BIT];

	// ==========================================================
	// Read configuration
	// Only a config write opens burst mode; reset returns to async
	always_ff @(posedge i_clk) begin
		if (i_rst || !hw_on) begin
			rcr_q <= RCR_RST; // R7
			sync_q <= !RCR_RST[RCR_ASYNC_BIT];
		end else if (i_rcr_wr) begin
			rcr_q <= i_rcr_data; // R22
			sync_q <= !i_rcr_data[RCR_ASYNC_BIT];
		end
	end

	assign o_sync_mode = sync_q;

	// ==========================================================
	// Link domain: clocked address capture
	// Link clock may stop between frames, so nothing here must end
	logic lk_rst;
	nfb_lpins_s lp;
	logic [ADDR_MSB:ADDR_LSB] lk_a_s;
	logic [ADDR_MSB:ADDR_LSB] lk_addr_q;
	logic lk_tgl_q;
	logic lk_done_q;
	logic lk_cap;

	nfb_sync #(.W(1), .RST_VAL(1'h1)) u_lk_rst_sync (
		.i_clk(i_link_clk),
		.i_rst(1'h0),
		.i_d(i_rst),
		.o_q(lk_rst)
	);

	nfb_sync #(.W($bits(nfb_lpins_s)), .RST_VAL(LPINS_IDLE)) u_lk_pin_sync (
		.i_clk(i_link_clk),
		.i_rst(lk_rst),
		.i_d({i_pins.ce_n, i_pins.we_n, i_pins.adv_n, i_pins.rst_n, rcr_q[RCR_ASYNC_BIT]}),
		.o_q(lp)
	);

	nfb_sync #(.W(ADDR_MSB)) u_lk_addr_sync (
		.i_clk(i_link_clk),
		.i_rst(lk_rst),
		.i_d(i_addr),
		.o_q(lk_a_s)
	);

	assign lk_cap = !lp.async_mode && !lp.adv_n && !lp.ce_n && lp.we_n && lp.rst_n && !lk_done_q;

	always_ff @(posedge i_link_clk) begin
		if (lk_rst) begin
			lk_addr_q <= '0;
			lk_tgl_q <= 1'h0;
			lk_done_q <= 1'h0;
		end else begin
			if (lk_cap) begin
				lk_addr_q <= lk_a_s; // R3
				lk_tgl_q <= !lk_tgl_q;
			end
			// One capture per address phase
			lk_done_q <= lk_cap || (lk_done_q && !lp.adv_n);
		end
	end

	// ==========================================================
	// Capture event back into core domain
	// Word stays stable until the next address phase, so the toggle
	// qualifies it
	logic tgl_s;
	logic tgl_prev_q;
	logic lk_evt;

	nfb_sync #(.W(1)) u_tgl_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d(lk_tgl_q),
		.o_q(tgl_s)
	);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tgl_prev_q <= 1'h0;
		end else begin
			tgl_prev_q <= tgl_s;
		end
	end

	assign lk_evt = tgl_s ^ tgl_prev_q;

	// ==========================================================
	// Address latch
	logic adv_prev_q;
	logic adv_rise;
	logic [ADDR_MSB:ADDR_LSB] addr_q;

	assign adv_rise = p.adv_n && !adv_prev_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			adv_prev_q <= 1'h1;
		end else begin
			adv_prev_q <= p.adv_n;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			addr_q <= '0;
		end else if (sync_mode) begin
			if (lk_evt) begin
				addr_q <= lk_addr_q; // R3
			end else if (adv_rise && !p.ce_n && p.we_n && hw_on) begin
				addr_q <= a_s; // R3
			end
		end else if (!p.adv_n) begin
			addr_q <= a_s; // R4 R1
		end
	end

	assign o_arr_addr = addr_q;

	// ==========================================================
	// Read data and wait outputs
	logic wait_act;

	assign wait_act = sync_mode && rd_sel && !i_arr_rvalid;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_dq <= '0;
			o_dq_oe_n <= 1'h1;
			o_wait_oe_n <= 1'h1;
		end else begin
			o_dq <= rd_sel ? i_arr_rdata : '0; // R2
			o_dq_oe_n <= !rd_sel; // R5 R6 R7
			o_wait_oe_n <= !out_sel; // R5 R6
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_wait <= !RCR_RST[RCR_WT_BIT];
		end else begin
			o_wait <= wait_act ? wt : !wt; // R8 R9
		end
	end

	// ==========================================================
	// Write capture
	// Sampling ends on the first rising strobe or select
	logic wr_prev_q;
	logic [DQ_W-1:0] wd_q;
	logic [ADDR_MSB:ADDR_LSB] wa_q;
	logic wr_end;

	assign wr_end = wr_prev_q && !wr_sel && hw_on;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_prev_q <= 1'h0;
			wd_q <= '0;
			wa_q <= '0;
		end else begin
			wr_prev_q <= wr_sel;
			if (wr_sel) begin
				wd_q <= d_s; // R12
				wa_q <= a_s;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_wreq <= '0;
			o_wr_addr <= '0;
		end else begin
			o_wreq.stb <= wr_end; // R12 R7
			o_wreq.allow <= !p.prog_lockout; // R14
			o_wreq.data <= wd_q;
			o_wr_addr <= wa_q;
		end
	end

	// ==========================================================
	// Protection, abort and activity
	logic hw_prev_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hw_prev_q <= 1'h0;
			o_abort <= 1'h0;
			o_ldown_ovr <= 1'h0;
			o_active <= 1'h0;
		end else begin
			hw_prev_q <= hw_on;
			o_abort <= i_op_busy && hw_prev_q && !hw_on; // R16
			o_ldown_ovr <= p.wp_n && hw_on; // R13
			o_active <= !p.ce_n || i_op_busy; // R17
		end
	end

	// ==========================================================
	// Status
	// Lockout error is sticky until reset; nothing clears it here
	always_ff @(posedge i_clk) begin
		if (i_rst || !hw_on) begin
			o_status <= STATUS_RST; // R15
		end else begin
			o_status[SR_READY_BIT] <= !i_op_busy;
			if (wr_end && p.prog_lockout) begin
				o_status[SR_LOCKOUT_BIT] <= 1'h1; // R14
			end
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	a_standby_float: assert property (p.ce_n |=> o_dq_oe_n && o_wait_oe_n) // R5
		else $error("outputs driven while deselected");
	a_oe_float: assert property (p.oe_n |=> o_dq_oe_n && o_wait_oe_n) // R6
		else $error("outputs driven with output enable high");
	a_reset_quiet: assert property (!p.rst_n |=> o_dq_oe_n && o_wait_oe_n && !o_wreq.stb && !sync_mode) // R7
		else $error("activity during hardware reset");
	a_status_init: assert property ($rose(p.rst_n) |-> o_status == STATUS_RST && rcr_q == RCR_RST) // R15
		else $error("bad state after reset release");
	a_wait_valid: assert property (sync_mode && rd_sel && i_arr_rvalid |=> o_wait == !$past(wt)) // R8
		else $error("wait asserted with valid data");
	a_wait_invalid: assert property ( // R9
		sync_mode && rd_sel && !i_arr_rvalid |=> o_wait == $past(wt) && !o_wait_oe_n
	) else $error("wait not asserted with invalid data");
	a_wait_async: assert property (!sync_mode |=> o_wait == !$past(wt)) // R9
		else $error("wait asserted in async mode");
	a_read_drive: assert property (rd_sel ##1 rd_sel |-> !o_dq_oe_n && o_dq == $past(i_arr_rdata)) // R2
		else $error("read data not driven");
	a_write_take: assert property ( // R12
		wr_sel ##1 !wr_sel && hw_on |=> o_wreq.stb && o_wreq.data == $past(d_s, 2)
	) else $error("write data not taken at strobe end");
	a_lockout_gate: assert property (o_wreq.stb |-> o_wreq.allow == !$past(p.prog_lockout)) // R14
		else $error("write allowed under program lockout");
	a_abort_op: assert property ($fell(p.rst_n) && i_op_busy |=> o_abort) // R16
		else $error("busy operation not aborted by reset");
	a_active_busy: assert property (i_op_busy && p.ce_n |=> o_active) // R17
		else $error("device idle while operation busy");
	a_addr_flow: assert property (!sync_mode && !p.adv_n |=> addr_q == $past(a_s)) // R4
		else $error("async address not flowing");
	a_addr_clk: assert property (sync_mode && lk_evt |=> addr_q == $past(lk_addr_q)) // R3
		else $error("clocked address not captured");

	c_async_read: cover property (!sync_mode && rd_sel ##1 rd_sel);
	c_sync_wait: cover property (wait_act ##1 rd_sel && i_arr_rvalid);
	c_write: cover property (o_wreq.stb && o_wreq.allow);
	c_abort: cover property (o_abort);

endmodule : nfb_bus_if

// >>> src/nfb_pkg.sv
// Shared constants and carriers for the flash bus interface
package nfb_pkg;

	// ==========================================================
	// Widths and address span
	localparam int ADDR_MSB_BIG = 23;
	localparam int ADDR_MSB_SMALL = 22;
	localparam int ADDR_LSB = 1;
	localparam int DQ_W = 16;
	localparam int SR_W = 8;

	// ==========================================================
	// Read configuration and status fields and reset values
	localparam int RCR_WT_BIT = 10;
	localparam int RCR_ASYNC_BIT = 15;
	localparam logic [DQ_W-1:0] RCR_RST = 16'h8000;
	localparam logic [SR_W-1:0] STATUS_RST = 8'h80;
	localparam int SR_READY_BIT = 7;
	localparam int SR_LOCKOUT_BIT = 3;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic adv_n;
		logic rst_n;
		logic wp_n;
		logic prog_lockout;
	} nfb_pins_s;

	localparam nfb_pins_s PINS_IDLE = 7'h7e;

	typedef struct packed {
		logic stb;
		logic allow;
		logic [DQ_W-1:0] data;
	} nfb_wreq_s;

	// Link side view: ce_n, we_n, adv_n, rst_n, async mode
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic adv_n;
		logic rst_n;
		logic async_mode;
	} nfb_lpins_s;

	localparam nfb_lpins_s LPINS_IDLE = 5'h1f;

endpackage : nfb_pkg

// >>> src/nfb_sync.sv
// Two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module nfb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	// ==========================================================
	// First stage is read only by the second
	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= RST_VAL;
			o_q <= RST_VAL;
		end else begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end

endmodule : nfb_sync
